// file: rtl/stten_pkg.sv
/*
  Package for the serial trigger enable block: register map, field
  positions and reset values.
  Assumes a 32-bit AXI4-Lite register bus with byte addressing.
*/
package stten_pkg;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] TRIG_CTRL_OFS = 12'h008;
  localparam int CHAN_CNT = 8;
  localparam int SEL_W = 3;
  localparam int SEL_LSB = 0;
  localparam int RX_ARM_BIT = 4;
  localparam int TX_ARM_BIT = 5;
  localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
  localparam logic RX_ARM_RST = 1'h0;
  localparam logic TX_ARM_RST = 1'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : stten_pkg

// file: rtl/stten_top.sv
/*
  Trigger control of the serial port: one control register over
  AXI4-Lite, rising-edge detect on a selected event channel, and
  one-cycle receiver/transmitter enable command pulses.
  Assumes event channels are synchronous to I_CORE_CLK.
*/
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps

// Operation
// - with the tx arm bit set, each rising edge of the selected channel pulses the transmitter enable command.
// - with the rx arm bit set, each rising edge of the selected channel pulses the receiver enable command.
// - a 3-bit read-write select field in bits 2:0, reset zero, picks event channel n for value n.
// - one selected channel serves both arm bits independently, and with neither set it does nothing.
module stten_top
  import stten_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic [CHAN_CNT-1:0] I_EVENT_CHANNEL,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_RECEIVER_ENABLE_CMD,
  output logic O_TRANSMITTER_ENABLE_CMD
);

  function automatic logic hit_ctrl(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:2], 2'h0} == TRIG_CTRL_OFS;
  endfunction : hit_ctrl

  logic [SEL_W-1:0] sel_r, sel_nxt;
  logic rx_arm_r, rx_arm_nxt, tx_arm_r, tx_arm_nxt;
  logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic wstrb0_r, wstrb0_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic prev_r, prev_nxt;
  logic rx_cmd_r, rx_cmd_nxt, tx_cmd_r, tx_cmd_nxt;
  logic cur, edge_seen, do_write;

  assign O_AWREADY = !aw_full_r && !bvalid_r;
  assign O_WREADY = !w_full_r && !bvalid_r;
  assign O_ARREADY = !rvalid_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_RVALID = rvalid_r;
  assign O_RRESP = rresp_r;
  assign O_RDATA = rdata_r;
  assign O_RECEIVER_ENABLE_CMD = rx_cmd_r;
  assign O_TRANSMITTER_ENABLE_CMD = tx_cmd_r;

  assign cur = I_EVENT_CHANNEL[sel_r];
  assign edge_seen = cur && !prev_r;

  // write path: address and data caught in either order
  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    sel_nxt = sel_r;
    rx_arm_nxt = rx_arm_r;
    tx_arm_nxt = tx_arm_r;
    if (I_AWVALID && O_AWREADY) begin
      aw_full_nxt = 1'h1;
      awaddr_nxt = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      w_full_nxt = 1'h1;
      wdata_nxt = I_WDATA;
      wstrb0_nxt = I_WSTRB[0];
    end
    do_write = aw_full_r && w_full_r && !bvalid_r;
    if (do_write) begin
      aw_full_nxt = 1'h0;
      w_full_nxt = 1'h0;
      bvalid_nxt = 1'h1;
      bresp_nxt = hit_ctrl(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      // all fields live in byte lane 0; reserved bits are dropped
      if (hit_ctrl(awaddr_r) && wstrb0_r) begin
        sel_nxt = wdata_r[SEL_LSB +: SEL_W];
        rx_arm_nxt = wdata_r[RX_ARM_BIT];
        tx_arm_nxt = wdata_r[TX_ARM_BIT];
      end
    end else if (bvalid_r && I_BREADY) begin
      bvalid_nxt = 1'h0;
    end
  end

  // read path: one cycle from address to data
  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (I_ARVALID && O_ARREADY) begin
      rvalid_nxt = 1'h1;
      rdata_nxt = 32'h0000_0000;
      if (hit_ctrl(I_ARADDR)) begin
        rresp_nxt = RESP_OKAY;
        rdata_nxt[SEL_LSB +: SEL_W] = sel_r;
        rdata_nxt[RX_ARM_BIT] = rx_arm_r;
        rdata_nxt[TX_ARM_BIT] = tx_arm_r;
      end else begin
        rresp_nxt = RESP_SLVERR;
      end
    end else if (rvalid_r && I_RREADY) begin
      rvalid_nxt = 1'h0;
    end
  end

  // trigger: the select may change between samples; that can make
  // a spurious edge, a limitation accepted for a single-flop detector
  always_comb begin
    prev_nxt = cur;
    rx_cmd_nxt = edge_seen && rx_arm_r;
    tx_cmd_nxt = edge_seen && tx_arm_r;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sel_r <= SEL_RST;
      rx_arm_r <= RX_ARM_RST;
      tx_arm_r <= TX_ARM_RST;
      aw_full_r <= 1'h0;
      w_full_r <= 1'h0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'h0;
      bvalid_r <= 1'h0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'h0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      prev_r <= 1'h0;
      rx_cmd_r <= 1'h0;
      tx_cmd_r <= 1'h0;
    end else begin
      sel_r <= sel_nxt;
      rx_arm_r <= rx_arm_nxt;
      tx_arm_r <= tx_arm_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      prev_r <= prev_nxt;
      rx_cmd_r <= rx_cmd_nxt;
      tx_cmd_r <= tx_cmd_nxt;
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  tx_pulse_a: assert property (
    $rose(I_EVENT_CHANNEL[sel_r]) && $stable(sel_r) && tx_arm_r
    |=> O_TRANSMITTER_ENABLE_CMD)
    else $error("tx enable missing after armed edge");
  rx_pulse_a: assert property (
    $rose(I_EVENT_CHANNEL[sel_r]) && $stable(sel_r) && rx_arm_r
    |=> O_RECEIVER_ENABLE_CMD)
    else $error("rx enable missing after armed edge");
  sel_readback_a: assert property (
    I_ARVALID && O_ARREADY && hit_ctrl(I_ARADDR)
    |=> O_RDATA[SEL_LSB +: SEL_W] == $past(sel_r))
    else $error("select readback wrong");
  unarmed_quiet_a: assert property (
    !$past(rx_arm_r) && !$past(tx_arm_r)
    |-> !O_RECEIVER_ENABLE_CMD && !O_TRANSMITTER_ENABLE_CMD)
    else $error("enable pulse while unarmed");
  reserved_zero_a: assert property (
    O_RVALID |-> O_RDATA[31:6] == 26'h0 && !O_RDATA[3])
    else $error("reserved bits read nonzero");
  single_pulse_a: assert property (
    O_TRANSMITTER_ENABLE_CMD |=> !O_TRANSMITTER_ENABLE_CMD)
    else $error("tx enable longer than one cycle");
  rx_single_a: assert property (
    O_RECEIVER_ENABLE_CMD |=> !O_RECEIVER_ENABLE_CMD)
    else $error("rx enable longer than one cycle");
  no_edge_quiet_a: assert property (
    !$rose(I_EVENT_CHANNEL[sel_r]) && $stable(sel_r)
    |=> !O_RECEIVER_ENABLE_CMD)
    else $error("rx enable without an edge");
  tx_no_edge_a: assert property (
    !$rose(I_EVENT_CHANNEL[sel_r]) && $stable(sel_r)
    |=> !O_TRANSMITTER_ENABLE_CMD)
    else $error("tx enable without an edge");
  write_resp_a: assert property (
    aw_full_r && w_full_r && !bvalid_r |=> O_BVALID)
    else $error("write response late");

  both_cov: cover property (O_RECEIVER_ENABLE_CMD && O_TRANSMITTER_ENABLE_CMD);
  tx_only_cov: cover property (O_TRANSMITTER_ENABLE_CMD && !rx_arm_r);
  wr_cov: cover property (O_BVALID && I_BREADY && O_BRESP == RESP_OKAY);
  err_cov: cover property (O_RVALID && O_RRESP == RESP_SLVERR);

endmodule : stten_top

// file: verification/stten_event_src.sv
/*
  Stand-in for the event routing network: drives the eight channels.
  Assumes requests come synchronous to the core clock.
*/
`timescale 1ns/10ps
module stten_event_src (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_req,
  output logic [7:0] o_chan
);
  // channels are driven levels, never released, so idle is low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_chan <= 8'h00;
    else o_chan <= i_req;
  end
endmodule : stten_event_src

// file: verification/serial_trigger_enable_test.sv
/*
  Self-checking bench for the trigger enable block.
  Assumes the register bus answers within a few dozen cycles.
*/
`timescale 1ns/10ps
module serial_trigger_enable_test;
  import stten_pkg::*;
  logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, bry = 1'h0;
  logic arv = 1'h0, rry = 1'h0, awr, wr, bv, arr, rv, rxc, txc;
  logic [3:0] ws = 4'hF;
  logic [ADDR_W-1:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic [1:0] br, rr;
  logic [7:0] req = 8'h00, chan;
  int fail_count = 0, checked = 0, rx_n = 0, tx_n = 0, r0, t0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (rxc === 1'h1) rx_n++;
    if (txc === 1'h1) tx_n++;
  end
  stten_event_src src (.i_clk(clk), .i_rst(rst), .i_req(req), .o_chan(chan));
  stten_top dut (.I_CORE_CLK(clk), .I_RST(rst), .I_EVENT_CHANNEL(chan),
    .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wd),
    .I_WSTRB(ws), .I_WVALID(wv), .O_WREADY(wr), .O_BRESP(br),
    .O_BVALID(bv), .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv),
    .I_RREADY(rry), .O_RECEIVER_ENABLE_CMD(rxc),
    .O_TRANSMITTER_ENABLE_CMD(txc));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // pulse counts are compared apart from register values
  task automatic chk_pulse(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t pulses got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pulse
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wr) wv <= 1'h0;
      n++;
    end while (bv !== 1'h1 && n < 50);
    bry <= 1'h0;
    chk({29'h0, bv, br}, {29'h0, 1'h1, e});
  endtask : axw
  task automatic axr(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
      n++;
    end while (rv !== 1'h1 && n < 50);
    rry <= 1'h0;
    chk({29'h0, rv, rr}, {29'h0, 1'h1, e});
    chk(rd, d);
  endtask : axr
  // the channel stays high for len cycles, then low for gap cycles
  task automatic fire(input int ch, input int len, input int gap);
    @(posedge clk);
    req <= 8'h01 << ch;
    repeat (len) @(posedge clk);
    req <= 8'h00;
    repeat (gap) @(posedge clk);
  endtask : fire
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    int s, a;
    logic [31:0] v;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    axw(12'h00C, 32'h00000037, RESP_SLVERR);
    axr(12'h00C, 32'h00000000, RESP_SLVERR);
    axr(TRIG_CTRL_OFS, 32'h00000000, RESP_OKAY);
    for (s = 0; s < 8; s++) begin
      for (a = 0; a < 4; a++) begin
        v = {26'h0, a[1:0], 1'h0, s[2:0]};
        axw(TRIG_CTRL_OFS, v, RESP_OKAY);
        axr(TRIG_CTRL_OFS, v, RESP_OKAY);
        r0 = rx_n;
        t0 = tx_n;
        // an unselected channel must be ignored; a long high counts once
        fire((s + 1) % 8, 2, 4);
        fire(s, 1 + a, 4);
        chk_pulse(rx_n - r0, {31'h0, a[0]});
        chk_pulse(tx_n - t0, {31'h0, a[1]});
      end
    end
    // every field sits in lane 0, so a write without it keeps 0x37
    ws <= 4'hE;
    axw(TRIG_CTRL_OFS, 32'h00000010, RESP_OKAY);
    ws <= 4'hF;
    axr(TRIG_CTRL_OFS, 32'h00000037, RESP_OKAY);
    r0 = rx_n;
    t0 = tx_n;
    // channel 7 with both armed: edges two cycles apart
    repeat (3) fire(7, 1, 0);
    repeat (5) @(posedge clk);
    chk_pulse(rx_n - r0, 32'h3);
    chk_pulse(tx_n - t0, 32'h3);
    end_of_test();
  end
endmodule : serial_trigger_enable_test
